// ### core/iepc_pkg.sv
// package: register map, field layout and bus types for the interrupt enable/priority block
package iepc_pkg;
    localparam int unsigned NUM_SRC = 32;
    localparam int unsigned LANES = 4;
    localparam int unsigned PRI_WORDS = NUM_SRC / LANES;
    localparam int unsigned ADDR_W = 8;

    // byte addresses of the register words
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_FLAG = 8'h04;
    localparam logic [7:0] OFF_PRIO_BASE = 8'h10;
    localparam logic [7:0] OFF_PRIO_LAST = 8'h2C;

    // one byte lane of the priority word
    localparam int unsigned PRI_LSB = 2;
    localparam int unsigned PRI_W = 3;
    localparam int unsigned SUB_LSB = 0;
    localparam int unsigned SUB_W = 2;
    localparam logic [7:0] LANE_MASK = 8'h1F;

    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_FLAG = 32'h0000_0000;
    localparam logic [7:0] RST_LANE = 8'h00;
    localparam logic [2:0] PRI_OFF = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PRI_W-1:0] level;
        logic [SUB_W-1:0] sub;
    } iepc_cfg_t;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } iepc_rd_t;
endpackage : iepc_pkg

// ### core/iepc_src.sv
// one interrupt source: request flag, forward gate and registered configuration outputs
`timescale 1ns/1ps
module iepc_src (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_req,
    input wire logic i_flag_wr,
    input wire logic i_flag_wdata,
    input wire logic i_enable,
    input wire iepc_pkg::iepc_cfg_t i_cfg,
    output logic o_flag,
    output logic o_fwd,
    output iepc_pkg::iepc_cfg_t o_cfg
);
    logic flag_q, flag_d;
    logic fwd_q, fwd_d;
    iepc_pkg::iepc_cfg_t cfg_q, cfg_d;

    always_comb begin
        flag_d = flag_q;
        if (i_flag_wr) begin
            flag_d = i_flag_wdata;
        end
        // a request in the clearing cycle still lands
        if (i_req) begin
            flag_d = 1'b1;
        end
        fwd_d = flag_q && i_enable && (i_cfg.level != iepc_pkg::PRI_OFF);
        cfg_d = i_cfg;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flag_q <= 1'b0;
            fwd_q <= 1'b0;
            cfg_q <= '0;
        end else begin
            flag_q <= flag_d;
            fwd_q <= fwd_d;
            cfg_q <= cfg_d;
        end
    end

    assign o_flag = flag_q;
    assign o_fwd = fwd_q;
    assign o_cfg = cfg_q;
endmodule : iepc_src

// ### core/iepc_top.sv
// interrupt enable/priority configuration block with an AXI4-Lite register slave
`timescale 1ns/1ps
module iepc_top #(
    parameter int unsigned NUM_SRC = iepc_pkg::NUM_SRC
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [NUM_SRC-1:0] i_req,
    output logic [NUM_SRC-1:0] o_fwd,
    output logic [NUM_SRC-1:0] o_flag,
    output logic [NUM_SRC*3-1:0] o_level,
    output logic [NUM_SRC*2-1:0] o_sub,
    input wire logic [iepc_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [iepc_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    localparam int unsigned NW = NUM_SRC / iepc_pkg::LANES;

    logic [31:0] enable_q, enable_d;
    logic [7:0] lane_q [NUM_SRC];
    logic [7:0] lane_d [NUM_SRC];
    logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
    logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, ardy_q, ardy_d;
    logic [iepc_pkg::ADDR_W-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] bresp_q, bresp_d;
    iepc_pkg::iepc_rd_t rd_q, rd_d;
    logic do_wr;
    logic flag_wr;
    logic [NUM_SRC-1:0] flag_vec;

    // commit one cycle after both halves are held; the response is raised at the same edge as the store
    assign do_wr = aw_q && w_q && !b_q;
    // flag word writes go byte-wise like every other register
    assign flag_wr = do_wr && (awa_q == iepc_pkg::OFF_FLAG);

    function automatic logic prio_hit(input logic [iepc_pkg::ADDR_W-1:0] a);
        prio_hit = (a >= iepc_pkg::OFF_PRIO_BASE) && (a <= iepc_pkg::OFF_PRIO_LAST)
            && (a[1:0] == 2'h0);
    endfunction : prio_hit

    function automatic int unsigned prio_idx(input logic [iepc_pkg::ADDR_W-1:0] a);
        logic [iepc_pkg::ADDR_W-1:0] rel;
        rel = a - iepc_pkg::OFF_PRIO_BASE;
        prio_idx = int'(rel[iepc_pkg::ADDR_W-1:2]);
    endfunction : prio_idx

    function automatic logic map_hit(input logic [iepc_pkg::ADDR_W-1:0] a);
        map_hit = (a == iepc_pkg::OFF_ENABLE) || (a == iepc_pkg::OFF_FLAG) || prio_hit(a);
    endfunction : map_hit

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            iepc_pkg::iepc_cfg_t cfg_in;
            iepc_pkg::iepc_cfg_t cfg_out;
            assign cfg_in.level = lane_q[g][iepc_pkg::PRI_LSB +: iepc_pkg::PRI_W];
            assign cfg_in.sub = lane_q[g][iepc_pkg::SUB_LSB +: iepc_pkg::SUB_W];
            iepc_src u_src (
                .i_clk(i_clk),
                .i_srst(i_srst),
                .i_req(i_req[g]),
                .i_flag_wr(flag_wr && ws_q[g/8]),
                .i_flag_wdata(wd_q[g]),
                .i_enable(enable_q[g]),
                .i_cfg(cfg_in),
                .o_flag(flag_vec[g]),
                .o_fwd(o_fwd[g]),
                .o_cfg(cfg_out)
            );
            assign o_flag[g] = flag_vec[g];
            assign o_level[g*3 +: 3] = cfg_out.level;
            assign o_sub[g*2 +: 2] = cfg_out.sub;
        end
    endgenerate

    // write channel: address and data taken in either order, one write at a time
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        b_d = b_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bresp_d = bresp_q;
        enable_d = enable_q;
        for (int i = 0; i < NUM_SRC; i++) begin
            lane_d[i] = lane_q[i];
        end
        if (i_awvalid && !aw_q && !b_q) begin
            aw_d = 1'b1;
            awa_d = i_awaddr;
        end
        if (i_wvalid && !w_q && !b_q) begin
            w_d = 1'b1;
            wd_d = i_wdata;
            ws_d = i_wstrb;
        end
        if (do_wr) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            b_d = 1'b1;
            bresp_d = map_hit(awa_q) ? iepc_pkg::RESP_OKAY : iepc_pkg::RESP_SLVERR;
            for (int k = 0; k < 4; k++) begin
                if (ws_q[k]) begin
                    if (awa_q == iepc_pkg::OFF_ENABLE) begin
                        enable_d[k*8 +: 8] = wd_q[k*8 +: 8];
                    end
                    if (prio_hit(awa_q) && prio_idx(awa_q) < NW) begin
                        // unimplemented top bits never stored
                        lane_d[prio_idx(awa_q)*4 + k] = wd_q[k*8 +: 8]
                            & iepc_pkg::LANE_MASK;
                    end
                end
            end
        end
        if (b_q && i_bready) begin
            b_d = 1'b0;
        end
        // readies are registered from the next state so every port starts at a flop
        awrdy_d = !aw_d && !b_d;
        wrdy_d = !w_d && !b_d;
    end

    // read channel: data registered at the same edge that takes the address
    always_comb begin
        r_d = r_q;
        rd_d = rd_q;
        if (i_arvalid && !r_q) begin
            r_d = 1'b1;
            rd_d.resp = iepc_pkg::RESP_OKAY;
            rd_d.data = 32'h0000_0000;
            if (i_araddr == iepc_pkg::OFF_ENABLE) begin
                rd_d.data = enable_q;
            end else if (i_araddr == iepc_pkg::OFF_FLAG) begin
                rd_d.data = flag_vec;
            end else if (prio_hit(i_araddr) && prio_idx(i_araddr) < NW) begin
                for (int k = 0; k < 4; k++) begin
                    rd_d.data[k*8 +: 8] = lane_q[prio_idx(i_araddr)*4 + k];
                end
            end else begin
                rd_d.resp = iepc_pkg::RESP_SLVERR;
            end
        end else if (r_q && i_rready) begin
            r_d = 1'b0;
        end
        // a new address waits until the previous data has been taken
        ardy_d = !r_d;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            b_q <= 1'b0;
            r_q <= 1'b0;
            // readies come up high: a request may be taken at the first edge after reset
            awrdy_q <= 1'b1;
            wrdy_q <= 1'b1;
            ardy_q <= 1'b1;
            awa_q <= '0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            bresp_q <= iepc_pkg::RESP_OKAY;
            rd_q <= '0;
            enable_q <= iepc_pkg::RST_ENABLE;
            for (int i = 0; i < NUM_SRC; i++) begin
                lane_q[i] <= iepc_pkg::RST_LANE;
            end
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            b_q <= b_d;
            r_q <= r_d;
            awrdy_q <= awrdy_d;
            wrdy_q <= wrdy_d;
            ardy_q <= ardy_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bresp_q <= bresp_d;
            rd_q <= rd_d;
            enable_q <= enable_d;
            for (int i = 0; i < NUM_SRC; i++) begin
                lane_q[i] <= lane_d[i];
            end
        end
    end

    assign o_awready = awrdy_q;
    assign o_wready = wrdy_q;
    assign o_bvalid = b_q;
    assign o_bresp = bresp_q;
    assign o_arready = ardy_q;
    assign o_rvalid = r_q;
    assign o_rdata = rd_q.data;
    assign o_rresp = rd_q.resp;
endmodule : iepc_top

// ### testbench/iepc_checker.sv
// port assertions for the enable/priority block
`timescale 1ns/1ps
module iepc_checker #(
    parameter int unsigned NUM_SRC = 32
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [NUM_SRC-1:0] i_req,
    input wire logic [NUM_SRC-1:0] o_fwd,
    input wire logic [NUM_SRC-1:0] o_flag,
    input wire logic [NUM_SRC*3-1:0] o_level,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
    sequence rd_take; i_arvalid && o_arready; endsequence
    fwd_cause_a: assert property ((o_fwd & ~$past(o_flag)) == '0)
        else $error("fwd no flag");
    flag_set_a: assert property (i_req != '0 |=> (o_flag & $past(i_req)) == $past(i_req))
        else $error("flag missed");
    prio_zero_a: assert property (o_level[2:0] == 3'h0 |-> !o_fwd[0])
        else $error("prio0 fwd");
    wr_answer_a: assert property (wr_take |-> ##2 o_bvalid) else $error("no bvalid");
    rd_answer_a: assert property (rd_take |=> o_rvalid) else $error("no rvalid");
    wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("aw busy");
    rd_block_a: assert property (o_rvalid |-> !o_arready) else $error("ar busy");
    b_release_a: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("b stuck");
endmodule : iepc_checker
bind iepc_top iepc_checker #(.NUM_SRC(NUM_SRC)) u_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_req(i_req), .o_fwd(o_fwd), .o_flag(o_flag), .o_level(o_level),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid));

// ### testbench/iepc_arb_model.sv
// arbitration stand-in: highest level then subpriority wins, lowest index on a tie
`timescale 1ns/1ps
module iepc_arb_model (
    input wire logic [31:0] i_fwd,
    input wire logic [95:0] i_level,
    input wire logic [63:0] i_sub,
    output logic [4:0] o_src
);
    logic [4:0] key;
    always_comb begin
        o_src = 5'h00;
        key = 5'h00;
        for (int n = 0; n < 32; n++) begin
            if (i_fwd[n] && {i_level[3*n+:3], i_sub[2*n+:2]} > key) begin
                key = {i_level[3*n+:3], i_sub[2*n+:2]};
                o_src = 5'(n);
            end
        end
    end
endmodule : iepc_arb_model

// ### testbench/test_iepc_top.sv
// self-checking bench for the enable/priority block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module test_iepc_top;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [31:0] i_req = '0;
    logic [7:0] i_awaddr = '0;
    logic [7:0] i_araddr = '0;
    logic [31:0] i_wdata = '0;
    logic [3:0] i_wstrb = '0;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic [31:0] o_fwd, o_flag, o_rdata;
    logic [95:0] o_level;
    logic [63:0] o_sub;
    logic [1:0] o_bresp, o_rresp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [4:0] pick;
    int n_errors = 0;
    int n_compared = 0;
    iepc_top DUT (.*);
    iepc_arb_model MODEL (.i_fwd(o_fwd), .i_level(o_level), .i_sub(o_sub), .o_src(pick));
    initial forever #2 i_clk = ~i_clk;
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                      input logic [1:0] er = iepc_pkg::RESP_OKAY);
        int k;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid) break;
        end
        if (k == 50) begin n_errors++; close_out(); end
        i_bready <= 1'b0;
        `CHK(o_bresp, er)
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er = iepc_pkg::RESP_OKAY);
        int k;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid) break;
        end
        if (k == 50) begin n_errors++; close_out(); end
        i_rready <= 1'b0;
        `CHK(o_rdata, ed)
        `CHK(o_rresp, er)
        @(posedge i_clk);
    endtask : rd
    task automatic t_regs;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h2C, 32'h0);
        wr(8'h00, 32'hA5A5_5A5A);
        wr(8'h00, 32'hFFFF_FFFF, 4'h1);
        rd(8'h00, 32'hA5A5_5AFF);
        wr(8'h2C, 32'hFFFF_FFFF);
        rd(8'h2C, 32'h1F1F_1F1F);
        wr(8'h08, 32'h1, 4'hF, iepc_pkg::RESP_SLVERR);
        rd(8'h08, 32'h0, iepc_pkg::RESP_SLVERR);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_fwd;
        wr(8'h00, 32'h0000_000F);
        wr(8'h10, 32'h1D0E_0907);
        repeat (2) @(posedge i_clk);
        `CHK(o_level[11:0], 12'hED1)
        `CHK(o_sub[7:0], 8'h67)
        i_req <= 32'h0000_000F;
        @(posedge i_clk);
        i_req <= '0;
        repeat (2) @(posedge i_clk);
        `CHK(o_flag, 32'h0000_000F)
        `CHK(o_fwd, 32'h0000_000F)
        `CHK(pick, 5'h03)
        // level zero on an enabled, flagged source must still block it
        wr(8'h10, 32'h000E_0907);
        repeat (2) @(posedge i_clk);
        `CHK(o_fwd, 32'h0000_0007)
        `CHK(pick, 5'h02)
        wr(8'h10, 32'h000D_0E0D);
        repeat (2) @(posedge i_clk);
        `CHK(pick, 5'h01)
        wr(8'h00, 32'h0000_0005);
        repeat (2) @(posedge i_clk);
        `CHK(o_fwd, 32'h0000_0005)
        rd(8'h04, 32'h0000_000F);
        // a request standing over the clearing write must keep its flag
        i_req <= 32'h0000_0001;
        wr(8'h04, 32'h0);
        i_req <= '0;
        `CHK(o_flag, 32'h0000_0001)
        wr(8'h04, 32'h0);
        repeat (2) @(posedge i_clk);
        `CHK(o_fwd, 32'h0)
        $display("t_fwd done");
    endtask : t_fwd
    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_fwd();
        close_out();
    end
endmodule : test_iepc_top
